// ---- hdl/psc_config.v ----
// psc_config.v: configuration latches, serial and parallel load paths,
// output divider and test output of the clock synthesizer.
// assumes all i_p*/i_s*/i_out_en pins are asynchronous to i_core_clk and
// that i_core_clk stands in for the vco clock.
// the register port is for observation and the output gate only; the
// divider values themselves can only be set through the pins.
`timescale 1ns/10ps
`default_nettype none
`include "psc_defs.vh"

module psc_config (
   input  wire                    i_core_clk,
   input  wire                    i_reset,
   input  wire                    i_ser_load,
   input  wire                    i_ser_data,
   input  wire                    i_ser_clk,
   input  wire                    i_par_load,
   input  wire [`PSC_M_W-1:0]     i_par_m,
   input  wire [`PSC_N_W-1:0]     i_par_n,
   input  wire                    i_out_en,
   input  wire [`PSC_ADDR_W-1:0]  i_addr,
   input  wire [31:0]             i_wdata,
   input  wire                    i_wr,
   input  wire                    i_rd,
   output reg  [31:0]             o_rdata,
   output wire                    o_fout,
   output reg                     o_test,
   output reg  [`PSC_M_W-1:0]     o_loop_div,
   output reg  [`PSC_N_W-1:0]     o_out_div
);

   // two-stage synchronisers; idle levels match the pin pulls
   reg  [1:0]            s_load_sync_ff;
   reg  [1:0]            s_data_sync_ff;
   reg  [1:0]            s_clk_sync_ff;
   reg  [1:0]            p_load_sync_ff;
   reg  [1:0]            oe_sync_ff;
   reg  [`PSC_M_W-1:0]   pm_meta_ff;
   reg  [`PSC_M_W-1:0]   pm_sync_ff;
   reg  [`PSC_N_W-1:0]   pn_meta_ff;
   reg  [`PSC_N_W-1:0]   pn_sync_ff;
   reg                   s_clk_prev_ff;
   reg  [`PSC_SR_W-1:0]  shift_ff;
   reg  [`PSC_T_W-1:0]   test_sel_ff;
   reg                   ctrl_gate_ff;
   reg  [`PSC_M_W-1:0]   nxt_loop_div;
   reg  [`PSC_N_W-1:0]   nxt_out_div;
   reg  [`PSC_T_W-1:0]   nxt_test_sel;
   reg                   nxt_test;
   reg  [31:0]           nxt_rdata;
   wire                  ser_rise;
   wire                  fout_q;
   wire                  running;

   // frequency step for the selected output ratio, 16 MHz reference
   function [15:0] step_of;
      input [`PSC_N_W-1:0] sel;
      begin
         step_of = `PSC_STEP_DIV1_KHZ >> sel;
      end
   endfunction

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         s_load_sync_ff <= 2'h0;
         s_data_sync_ff <= 2'h0;
         s_clk_sync_ff  <= 2'h0;
         p_load_sync_ff <= 2'h3;
         oe_sync_ff     <= 2'h3;
         pm_meta_ff     <= `PSC_M_RST;
         pm_sync_ff     <= `PSC_M_RST;
         pn_meta_ff     <= `PSC_N_RST;
         pn_sync_ff     <= `PSC_N_RST;
      end else begin
         s_load_sync_ff <= {s_load_sync_ff[0], i_ser_load};
         s_data_sync_ff <= {s_data_sync_ff[0], i_ser_data};
         s_clk_sync_ff  <= {s_clk_sync_ff[0], i_ser_clk};
         p_load_sync_ff <= {p_load_sync_ff[0], i_par_load};
         oe_sync_ff     <= {oe_sync_ff[0], i_out_en};
         pm_meta_ff     <= i_par_m;
         pm_sync_ff     <= pm_meta_ff;
         pn_meta_ff     <= i_par_n;
         pn_sync_ff     <= pn_meta_ff;
      end
   end

   assign ser_rise = s_clk_sync_ff[1] && !s_clk_prev_ff;

   // serial shift path; first bit in ends at the top of the register
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         s_clk_prev_ff <= 1'b0;
         shift_ff      <= {`PSC_SR_W{1'b0}};
      end else begin
         s_clk_prev_ff <= s_clk_sync_ff[1];
         if (ser_rise)
            shift_ff <= {shift_ff[`PSC_SR_W-2:0], s_data_sync_ff[1]};
      end
   end

   // configuration latches; the serial strobe wins when both are open.
   // latches hold whatever was present when the strobe closed, so a host
   // changing data across the closing edge gets an undefined mix
   always @* begin
      nxt_loop_div = o_loop_div;
      nxt_out_div  = o_out_div;
      nxt_test_sel = test_sel_ff;
      if (s_load_sync_ff[1]) begin
         nxt_loop_div = shift_ff[`PSC_SR_M_LSB +: `PSC_M_W];
         nxt_out_div  = shift_ff[`PSC_SR_N_LSB +: `PSC_N_W];
         nxt_test_sel = shift_ff[`PSC_SR_T_LSB +: `PSC_T_W];
      end else if (!p_load_sync_ff[1]) begin
         nxt_loop_div = pm_sync_ff;
         nxt_out_div  = pn_sync_ff;
      end
   end

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_loop_div  <= `PSC_M_RST;
         o_out_div   <= `PSC_N_RST;
         test_sel_ff <= `PSC_T_RST;
      end else begin
         o_loop_div  <= nxt_loop_div;
         o_out_div   <= nxt_out_div;
         test_sel_ff <= nxt_test_sel;
      end
   end

   psc_out_div u_div (
      .i_core_clk   (i_core_clk),
      .i_reset      (i_reset),
      .i_ratio_sel  (o_out_div),
      .i_enable     (oe_sync_ff[1] && ctrl_gate_ff),
      .o_fout_ff    (fout_q),
      .o_running_ff (running)
   );
   assign o_fout = fout_q;

   // test output selection; codes beyond these read low
   always @* begin
      nxt_test = 1'b0;
      case (test_sel_ff)
         3'h0:    nxt_test = shift_ff[`PSC_SR_W-1];
         3'h1:    nxt_test = 1'b1;
         3'h2:    nxt_test = fout_q;
         3'h3:    nxt_test = running;
         3'h4:    nxt_test = s_clk_sync_ff[1];
         default: nxt_test = 1'b0;
      endcase
   end

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset)
         o_test <= 1'b0;
      else
         o_test <= nxt_test;
   end

   // register port: one control bit, readback of latched state
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset)
         ctrl_gate_ff <= `PSC_CTRL_RST;
      else if (i_wr && i_addr == `PSC_REG_CTRL)
         ctrl_gate_ff <= i_wdata[0];
   end

   // read data stand for one cycle only, so idle reads return zero
   always @* begin
      nxt_rdata = 32'h0;
      if (i_rd) begin
         case (i_addr)
            `PSC_REG_CTRL:  nxt_rdata = {30'h0, running, ctrl_gate_ff};
            `PSC_REG_CFG:   nxt_rdata = {18'h0, test_sel_ff,
                                         o_out_div, o_loop_div};
            `PSC_REG_SHIFT: nxt_rdata = {18'h0, shift_ff};
            `PSC_REG_STEP:  nxt_rdata = {16'h0, step_of(o_out_div)};
            default:        nxt_rdata = 32'h0;
         endcase
      end
   end

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset)
         o_rdata <= 32'h0;
      else
         o_rdata <= nxt_rdata;
   end

endmodule
`default_nettype wire

// ---- pkg/psc_defs.vh ----
// psc_defs.vh: constants for the synthesizer configuration logic.
// assumes inclusion by bare name from the hdl files; definitions only.
//
// Behaviour
// - output divider codes 00,01,10,11 give division by 1,2,4,8; psc_out_div divides i_core_clk by 2,4,8,16
// - serial strobe high passes shift register through; falling edge holds
// - each serial clock rising edge shifts the serial data bit in
// - parallel strobe low passes divider inputs through; rising edge holds
// - two-bit output divider taken at parallel strobe rise
// - output enable 0 disables, 1 enables, switched without runt pulses
// - three-bit test select chooses test output, loaded only serially
// - idle serial pins read low; parallel pins and enable read high
// - 16 MHz reference gives steps 1.0 MHz to 125 kHz by divider
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

`define PSC_M_W          9
`define PSC_N_W          2
`define PSC_T_W          3
`define PSC_SR_W         14
// shift register layout, first bit shifted in ends at the top
`define PSC_SR_M_LSB     0
`define PSC_SR_N_LSB     9
`define PSC_SR_T_LSB     11
`define PSC_M_RST        9'h1FF
`define PSC_N_RST        2'h3
`define PSC_T_RST        3'h0
// register port
`define PSC_ADDR_W       4
`define PSC_REG_CTRL     4'h0
`define PSC_REG_CFG      4'h4
`define PSC_REG_SHIFT    4'h8
`define PSC_REG_STEP     4'hC
`define PSC_CTRL_RST     1'h1
// reference and step figures, in kHz
`define PSC_REF_KHZ      16000
`define PSC_STEP_DIV1_KHZ 16'h03E8

`endif

// ---- hdl/psc_out_div.v ----
// psc_out_div.v: output divider with glitch-free synchronous enable.
// assumes enable and ratio come from flops on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "psc_defs.vh"

module psc_out_div (
   input  wire                  i_core_clk,
   input  wire                  i_reset,
   input  wire [`PSC_N_W-1:0]   i_ratio_sel,
   input  wire                  i_enable,
   output reg                   o_fout_ff,
   output reg                   o_running_ff
);

   reg  [2:0] cnt_ff;
   wire [2:0] nxt_cnt;
   wire       half_done;

   function [2:0] ratio_last;
      input [`PSC_N_W-1:0] sel;
      begin
         case (sel)
            2'h0:    ratio_last = 3'h0;
            2'h1:    ratio_last = 3'h1;
            2'h2:    ratio_last = 3'h3;
            default: ratio_last = 3'h7;
         endcase
      end
   endfunction

   // each half period lasts 1,2,4 or 8 clocks
   assign half_done = (cnt_ff >= ratio_last(i_ratio_sel));
   assign nxt_cnt   = half_done ? 3'h0 : cnt_ff + 3'h1;

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt_ff       <= 3'h0;
         o_fout_ff    <= 1'b0;
         o_running_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         // enable changes only at a low-phase boundary: no runt pulse
         if (half_done && !o_fout_ff)
            o_running_ff <= i_enable;
         if (half_done)
            o_fout_ff <= o_fout_ff ? 1'b0
                       : ((o_fout_ff == 1'b0) &&
                          ((o_running_ff && i_enable) ||
                           (!o_running_ff && i_enable)));
      end
   end

endmodule
`default_nettype wire

// ---- hdl/psc_unused_placeholder_none.v ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- test/psc_config_monitor.sv ----
// psc_config_monitor.sv: port assertions for the configuration logic.
// assumes a bind onto psc_config and pins held long enough to synchronise.
`timescale 1ns/10ps
`default_nettype none
module psc_config_monitor (
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic        i_ser_load,
   input wire logic        i_par_load,
   input wire logic [8:0]  i_par_m,
   input wire logic        i_out_en,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_fout,
   input wire logic [8:0]  o_loop_div,
   input wire logic [1:0]  o_out_div
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   AST_CFG_RD: assert property ($past(i_rd) && $past(i_addr) == 4'h4 |->
      o_rdata[10:0] == {$past(o_out_div), $past(o_loop_div)}) else $error("cfg");
   AST_HOLD: assert property ((!i_ser_load && i_par_load)[*5] |->
      $stable(o_loop_div) && $stable(o_out_div)) else $error("hold");
   AST_PAR_M: assert property ((!i_par_load && !i_ser_load &&
      $stable(i_par_m))[*5] |-> o_loop_div == i_par_m) else $error("par");
   AST_OFF: assert property ((!i_out_en)[*8] ##1 (!i_out_en)[*8] |->
      !o_fout) else $error("off");
   AST_DIV1: assert property ((o_out_div == 2'h0)[*8] ##0 $rose(o_fout)
      |=> !o_fout) else $error("div1");
   AST_DIV4: assert property ((o_out_div == 2'h2)[*8] ##0 $rose(o_fout)
      |-> o_fout[*4] ##1 !o_fout) else $error("div4");
   AST_DIV8: assert property ((o_out_div == 2'h3)[*8] ##0 $rose(o_fout)
      |-> o_fout[*8] ##1 !o_fout) else $error("div8");
   AST_GATE: assert property (i_wr && i_addr == 4'h0 ##1 i_rd &&
      i_addr == 4'h0 |=> o_rdata[0] == $past(i_wdata[0], 2)) else $error("gate");
   cover property ((o_out_div == 2'h3) && $rose(o_fout));
   cover property ($rose(i_par_load));
   cover property (i_wr ##1 i_rd);
endmodule
`default_nettype wire

// ---- test/psc_ser_host.sv ----
// psc_ser_host.sv: host model driving the three serial configuration pins.
// assumes each call starts just after a rising edge of i_core_clk.
`timescale 1ns/10ps
`default_nettype none
module psc_ser_host (
   input  wire logic i_core_clk,
   output var logic  o_ser_load,
   output var logic  o_ser_data,
   output var logic  o_ser_clk
);
   initial begin
      o_ser_load = 1'b0;
      o_ser_data = 1'b0;
      o_ser_clk = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // msb first: test field goes in first, loop divider last
   task automatic send(input logic [13:0] word);
      for (int i = 13; i >= 0; i--) begin
         o_ser_data <= word[i];
         wait_clk(3);
         o_ser_clk <= 1'b1;
         wait_clk(3);
         o_ser_clk <= 1'b0;
      end
      wait_clk(3);
      o_ser_load <= 1'b1;
      wait_clk(4);
      o_ser_load <= 1'b0;
      wait_clk(3);
      o_ser_data <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- test/psc_config_bench.sv ----
// psc_config_bench.sv: self-checking bench for the configuration logic.
// assumes the host model owns the serial pins; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
`include "psc_defs.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module psc_config_bench;
   logic        i_core_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic        i_par_load = 1'b1, i_out_en = 1'b1;
   logic [8:0]  i_par_m = 9'h1FF;
   logic [1:0]  i_par_n = 2'h3;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   wire         i_ser_load, i_ser_data, i_ser_clk, o_fout, o_test;
   wire  [31:0] o_rdata;
   wire  [8:0]  o_loop_div;
   wire  [1:0]  o_out_div;
   int          n_fail = 0, compares = 0;
   psc_ser_host host (.i_core_clk(i_core_clk), .o_ser_load(i_ser_load),
      .o_ser_data(i_ser_data), .o_ser_clk(i_ser_clk));
   psc_config dut (.*);
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      tick(1);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
      i_addr <= a;
      i_rd <= 1'b1;
      tick(1);
      i_rd <= 1'b0;
      tick(1);
      `CHK(o_rdata & m, e)
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial forever #5 i_core_clk = ~i_core_clk;
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   initial begin
      tick(5);
      i_reset <= 1'b0;
      tick(4);
      rd(`PSC_REG_CFG, 32'h7FF, 32'h3FFF);
      for (int n = 0; n < 4; n++) begin
         i_out_en <= 1'b0;
         tick(12);
         i_par_m <= 9'h0A5 + 9'(n);
         i_par_n <= 2'(n);
         i_par_load <= 1'b0;
         tick(6);
         i_par_load <= 1'b1;
         tick(3);
         i_par_m <= ~i_par_m;
         tick(8);
         `CHK(o_fout, 1'b0)
         `CHK(o_out_div, 2'(n))
         rd(`PSC_REG_CFG, {21'h0, 2'(n), 9'h0A5 + 9'(n)}, 32'h7FF);
         i_out_en <= 1'b1;
         tick(40);
      end
      i_out_en <= 1'b0;
      tick(12);
      host.send({3'h1, 2'h3, 9'h123});
      tick(4);
      rd(`PSC_REG_SHIFT, {18'h0, 3'h1, 2'h3, 9'h123}, 32'h3FFF);
      rd(`PSC_REG_CFG, {18'h0, 3'h1, 2'h3, 9'h123}, 32'h3FFF);
      `CHK(o_test, 1'b1)
      rd(`PSC_REG_STEP, 32'h7D, 32'hFFFF);
      i_out_en <= 1'b1;
      wr(`PSC_REG_CTRL, 32'h0);
      rd(`PSC_REG_CTRL, 32'h0, 32'h1);
      tick(20);
      `CHK(o_fout, 1'b0)
      wr(`PSC_REG_CTRL, 32'h1);
      rd(4'h2, 32'h0, 32'hFFFFFFFF);
      tick(30);
      end_of_test;
   end
endmodule
bind psc_config psc_config_monitor mon (.*);
`default_nettype wire
